// ---- core/seq_in_cond.sv ----
// Synchronises and debounces each sequence input pin except gp_input_one_in, which servo_seq_ctrl only synchronises.
// Assumes raw pins are asynchronous to sys_clk_in.
`timescale 1ns/1ps
module seq_in_cond
    import seq_pkg::*;
(
    input wire logic sys_clk_in,
    input wire logic rst_in,
    input wire logic [N_IN-1:0] pins_in,
    seq_in_if.src cond
);
    logic [N_IN-1:0] s1_q, s2_q, lvl_q, lvl_d, rise_q, rise_d;
    logic [DEB_CNT_W-1:0] cnt_q [N_IN];
    logic [DEB_CNT_W-1:0] cnt_d [N_IN];

    // An input is accepted once it stays stable for the debounce time.
    genvar g;
    for (g = 0; g < N_IN; g++) begin : g_in
        always_comb begin
            cnt_d[g] = '0;
            lvl_d[g] = lvl_q[g];
            rise_d[g] = 1'b0;
            if (s2_q[g] != lvl_q[g]) begin
                if (cnt_q[g] == DEB_LAST) begin
                    lvl_d[g] = s2_q[g];
                    rise_d[g] = s2_q[g];
                end else begin
                    cnt_d[g] = cnt_q[g] + 1'b1;
                end
            end
        end
        always_ff @(posedge sys_clk_in) begin
            if (rst_in) begin
                cnt_q[g] <= '0;
            end else begin
                cnt_q[g] <= cnt_d[g];
            end
        end
    end

    always_ff @(posedge sys_clk_in) begin
        if (rst_in) begin
            s1_q <= '0;
            s2_q <= '0;
            lvl_q <= COND_LVL_RST;
            rise_q <= '0;
        end else begin
            s1_q <= pins_in;
            s2_q <= s1_q;
            lvl_q <= lvl_d;
            rise_q <= rise_d;
        end
    end

    assign cond.level = lvl_q;
    assign cond.rise = rise_q;
endmodule

// ---- core/seq_in_if.sv ----
// Carries the conditioned sequence inputs from the input conditioner.
// Assumes both ends share sys_clk_in.
`timescale 1ns/1ps
interface seq_in_if;
    logic [seq_pkg::N_IN-1:0] level;
    logic [seq_pkg::N_IN-1:0] rise;
    modport src (output level, output rise);
    modport dst (input level, input rise);
endinterface

// ---- core/seq_pkg.sv ----
// Constants and types shared by the speed limit and sequence input logic.
// Assumes a single 200 MHz clock domain and a synchronous active-high reset.
package seq_pkg;
    localparam int unsigned CLK_HZ = 200000000;
    localparam int unsigned SPEED_W = 16;
    localparam int unsigned POS_W = 32;
    localparam int unsigned TLIM_SEL_W = 4;
    // Debounce time in microseconds and its cycle count.
    localparam int unsigned DEBOUNCE_US = 100;
    localparam int unsigned DEBOUNCE_CYC = (CLK_HZ / 1000000) * DEBOUNCE_US;
    localparam int unsigned DEB_CNT_W = 15;
    localparam logic [DEB_CNT_W-1:0] DEB_LAST = DEB_CNT_W'(DEBOUNCE_CYC - 1);
    localparam logic [7:0] ESTOP_ALARM_CODE = 8'h57;
    localparam logic [TLIM_SEL_W-1:0] TLIM_SEL_PIN_A = 4'h3;
    localparam logic [TLIM_SEL_W-1:0] TLIM_SEL_PIN_B = 4'h5;
    localparam logic ESTOP_ENABLE_RST = 1'b1;
    localparam logic [1:0] OT_ASSIGN_DEFAULT = 2'h0;
    // Input vector positions of the debounced sequence inputs.
    localparam int unsigned N_IN = 11;
    localparam int unsigned I_ESTOP = 0;
    localparam int unsigned I_LATCH_A = 1;
    localparam int unsigned I_LATCH_B = 2;
    localparam int unsigned I_LATCH_C = 3;
    localparam int unsigned I_FTL = 4;
    localparam int unsigned I_RTL = 5;
    localparam int unsigned I_OT_P19 = 6;
    localparam int unsigned I_OT_P20 = 7;
    localparam int unsigned I_PROX = 8;
    localparam int unsigned I_GP0 = 9;
    localparam int unsigned I_GP2 = 10;
    // The stop input starts as connected, so reset alone raises no alarm.
    localparam logic [N_IN-1:0] COND_LVL_RST = N_IN'(1 << I_ESTOP);
    typedef enum logic [2:0] {
        ST_RUN = 3'b001,
        ST_FWD_STOP = 3'b010,
        ST_REV_STOP = 3'b100
    } ot_state_e;
endpackage

// ---- core/servo_seq_ctrl.sv ----
// Speed limit in torque control and sequence input handling of a servo drive.
// Assumes settings are static between changes and pins are asynchronous.
`timescale 1ns/1ps
module servo_seq_ctrl
    import seq_pkg::*;
(
    // Clock and reset.
    input wire logic sys_clk_in,
    input wire logic rst_in,
    // Speed limit.
    input wire logic torque_mode_in,
    input wire logic [seq_pkg::SPEED_W-1:0] internal_speed_limit_in,
    input wire logic [seq_pkg::SPEED_W-1:0] net_speed_limit_in,
    input wire logic speed_limit_source_sel_in,
    input wire logic [seq_pkg::SPEED_W-1:0] speed_cmd_mag_in,
    // Settings.
    input wire logic estop_input_enable_n_in,
    input wire logic [seq_pkg::TLIM_SEL_W-1:0] torque_limit_sel_in,
    input wire logic overtravel_input_enable_in,
    input wire logic [1:0] overtravel_stop_method_in,
    input wire logic origin_prox_polarity_in,
    input wire logic [1:0] overtravel_pin_assign_in,
    // Field pins.
    input wire logic estop_in,
    input wire logic latch_in_a_in,
    input wire logic latch_in_b_in,
    input wire logic latch_in_c_in,
    input wire logic fwd_torque_lim_in,
    input wire logic rev_torque_lim_in,
    input wire logic fwd_overtravel_in,
    input wire logic rev_overtravel_in,
    input wire logic origin_prox_in,
    input wire logic gp_input_zero_in,
    input wire logic gp_input_one_in,
    input wire logic gp_input_two_in,
    // Feedback.
    input wire logic [seq_pkg::POS_W-1:0] fb_pos_in,
    // Speed limit results.
    output logic [seq_pkg::SPEED_W-1:0] speed_limit_out,
    output logic [seq_pkg::SPEED_W-1:0] speed_cmd_limited_out,
    output logic speed_limited_out,
    // Alarm.
    output logic estop_alarm_out,
    output logic [7:0] alarm_code_out,
    // Latches.
    output logic [seq_pkg::POS_W-1:0] latch_pos_a_out,
    output logic [seq_pkg::POS_W-1:0] latch_pos_b_out,
    output logic [seq_pkg::POS_W-1:0] latch_pos_c_out,
    output logic [2:0] latch_done_out,
    // Torque limit selection.
    output logic use_fwd_tlim_out,
    output logic use_rev_tlim_out,
    // Overtravel stop.
    output logic fwd_prohibit_out,
    output logic rev_prohibit_out,
    output logic [1:0] stop_method_out,
    // Origin and general inputs.
    output logic origin_prox_out,
    output logic [2:0] gp_inputs_out
);
    seq_in_if cond_if ();
    logic [N_IN-1:0] pins;
    logic gp1_s1_q, gp1_s2_q;

    assign pins = {gp_input_two_in, gp_input_zero_in, origin_prox_in, rev_overtravel_in,
                   fwd_overtravel_in, rev_torque_lim_in, fwd_torque_lim_in, latch_in_c_in,
                   latch_in_b_in, latch_in_a_in, estop_in};

    seq_in_cond u_cond (
        .sys_clk_in(sys_clk_in),
        .rst_in(rst_in),
        .pins_in(pins),
        .cond(cond_if.src)
    );

    // Speed limit path.
    logic [SPEED_W-1:0] lim_d, lim_q, cmd_d, cmd_q;
    logic hit_d, hit_q;
    always_comb begin
        lim_d = internal_speed_limit_in;
        if (speed_limit_source_sel_in && net_speed_limit_in < internal_speed_limit_in) begin
            lim_d = net_speed_limit_in;
        end
        cmd_d = speed_cmd_mag_in;
        hit_d = 1'b0;
        // Magnitude cap, so it applies the same way in either direction.
        if (torque_mode_in && speed_cmd_mag_in > lim_q) begin
            cmd_d = lim_q;
            hit_d = 1'b1;
        end
    end
    always_ff @(posedge sys_clk_in) begin
        if (rst_in) begin
            lim_q <= '0;
            cmd_q <= '0;
            hit_q <= 1'b0;
        end else begin
            lim_q <= lim_d;
            cmd_q <= cmd_d;
            hit_q <= hit_d;
        end
    end

    // Emergency stop: pin high means supply connected, hence not tripped.
    logic alarm_d, alarm_q;
    logic [7:0] code_d, code_q;
    always_comb begin
        alarm_d = !estop_input_enable_n_in == ESTOP_ENABLE_RST && !cond_if.level[I_ESTOP];
        // The code is registered beside the alarm so that both change on one edge.
        code_d = alarm_d ? ESTOP_ALARM_CODE : 8'h00;
    end
    always_ff @(posedge sys_clk_in) begin
        if (rst_in) begin
            alarm_q <= 1'b0;
            code_q <= 8'h00;
        end else begin
            alarm_q <= alarm_d;
            code_q <= code_d;
        end
    end

    // Position latches.
    logic [POS_W-1:0] lp_q [3];
    logic [POS_W-1:0] lp_d [3];
    logic [2:0] done_d, done_q;
    genvar k;
    for (k = 0; k < 3; k++) begin : g_lat
        always_comb begin
            lp_d[k] = lp_q[k];
            done_d[k] = 1'b0;
            if (cond_if.rise[I_LATCH_A + k]) begin
                lp_d[k] = fb_pos_in;
                done_d[k] = 1'b1;
            end
        end
        always_ff @(posedge sys_clk_in) begin
            if (rst_in) begin
                lp_q[k] <= '0;
            end else begin
                lp_q[k] <= lp_d[k];
            end
        end
    end

    // Torque limit, overtravel, origin and general inputs.
    logic ftl_d, rtl_d, ftl_q, rtl_q, prox_d, prox_q;
    logic fwd_ot, rev_ot;
    logic [1:0] meth_q;
    logic [2:0] gp_d, gp_q;
    ot_state_e ot_q, ot_d;
    always_comb begin
        ftl_d = 1'b0;
        rtl_d = 1'b0;
        if (torque_limit_sel_in == TLIM_SEL_PIN_A || torque_limit_sel_in == TLIM_SEL_PIN_B) begin
            ftl_d = cond_if.level[I_FTL];
            rtl_d = cond_if.level[I_RTL];
        end
        // Assignment default maps pin 19 forward and pin 20 reverse; else swapped.
        if (overtravel_pin_assign_in == OT_ASSIGN_DEFAULT) begin
            fwd_ot = cond_if.level[I_OT_P19];
            rev_ot = cond_if.level[I_OT_P20];
        end else begin
            fwd_ot = cond_if.level[I_OT_P20];
            rev_ot = cond_if.level[I_OT_P19];
        end
        fwd_ot = fwd_ot && overtravel_input_enable_in;
        rev_ot = rev_ot && overtravel_input_enable_in;
        ot_d = ot_q;
        unique case (ot_q)
            ST_RUN: begin
                if (fwd_ot) begin
                    ot_d = ST_FWD_STOP;
                end else if (rev_ot) begin
                    ot_d = ST_REV_STOP;
                end
            end
            ST_FWD_STOP: begin
                if (!fwd_ot) begin
                    ot_d = rev_ot ? ST_REV_STOP : ST_RUN;
                end
            end
            ST_REV_STOP: begin
                if (!rev_ot) begin
                    ot_d = fwd_ot ? ST_FWD_STOP : ST_RUN;
                end
            end
        endcase
        prox_d = cond_if.level[I_PROX] ^ origin_prox_polarity_in;
        gp_d = {cond_if.level[I_GP2], gp1_s2_q, cond_if.level[I_GP0]};
    end
    always_ff @(posedge sys_clk_in) begin
        if (rst_in) begin
            ftl_q <= 1'b0;
            rtl_q <= 1'b0;
            ot_q <= ST_RUN;
            meth_q <= '0;
            prox_q <= 1'b0;
            gp_q <= '0;
            gp1_s1_q <= 1'b0;
            gp1_s2_q <= 1'b0;
            done_q <= '0;
        end else begin
            ftl_q <= ftl_d;
            rtl_q <= rtl_d;
            ot_q <= ot_d;
            meth_q <= overtravel_stop_method_in;
            prox_q <= prox_d;
            gp_q <= gp_d;
            gp1_s1_q <= gp_input_one_in;
            gp1_s2_q <= gp1_s1_q;
            done_q <= done_d;
        end
    end

    assign speed_limit_out = lim_q;
    assign speed_cmd_limited_out = cmd_q;
    assign speed_limited_out = hit_q;
    assign estop_alarm_out = alarm_q;
    assign alarm_code_out = code_q;
    assign latch_pos_a_out = lp_q[0];
    assign latch_pos_b_out = lp_q[1];
    assign latch_pos_c_out = lp_q[2];
    assign latch_done_out = done_q;
    assign use_fwd_tlim_out = ftl_q;
    assign use_rev_tlim_out = rtl_q;
    // One-hot state bits drive the prohibit outputs directly.
    assign fwd_prohibit_out = ot_q[1];
    assign rev_prohibit_out = ot_q[2];
    assign stop_method_out = meth_q;
    assign origin_prox_out = prox_q;
    assign gp_inputs_out = gp_q;
endmodule

// ---- dv/field_model.sv ----
// Field switches, host speed setting and feedback counter beside the block.
// Assumes the bench names the wanted levels; all of them move on the falling edge.
`timescale 1ns/1ps
module field_model #(
    parameter logic [seq_pkg::SPEED_W-1:0] MOTOR_MAX = 16'h1770
) (
    // Clock and reset.
    input wire logic sys_clk_in,
    input wire logic rst_in,
    // Requests from the bench.
    input wire logic [11:0] want_in,
    input wire logic [seq_pkg::SPEED_W-1:0] lim_req_in,
    // Pins, host setting and feedback.
    output logic [11:0] pins_out,
    output logic [seq_pkg::SPEED_W-1:0] internal_lim_out,
    output logic [seq_pkg::POS_W-1:0] fb_pos_out
);
    import seq_pkg::*;
    initial begin
        pins_out = '0;
        internal_lim_out = '0;
        fb_pos_out = '0;
    end
    always @(negedge sys_clk_in) begin
        // Levels stand until the bench changes them, so pulses last as long as asked.
        pins_out <= want_in;
        internal_lim_out <= (lim_req_in < MOTOR_MAX) ? lim_req_in : MOTOR_MAX - 16'h0001;
        fb_pos_out <= rst_in ? '0 : fb_pos_out + 32'h0000_0001;
    end
endmodule

// ---- dv/servo_seq_props.sv ----
// Checker for the speed limit and sequence input block.
// Assumes it is bound to servo_seq_ctrl and sees only its ports.
`timescale 1ns/1ps
module servo_seq_props (
    // Clock and reset.
    input wire logic sys_clk_in,
    input wire logic rst_in,
    // Inputs of the block.
    input wire logic torque_mode_in,
    input wire logic [seq_pkg::SPEED_W-1:0] speed_cmd_mag_in,
    input wire logic estop_input_enable_n_in,
    input wire logic overtravel_input_enable_in,
    input wire logic [1:0] overtravel_stop_method_in,
    input wire logic [seq_pkg::POS_W-1:0] fb_pos_in,
    // Outputs of the block.
    input wire logic [seq_pkg::SPEED_W-1:0] speed_limit_out,
    input wire logic [seq_pkg::SPEED_W-1:0] speed_cmd_limited_out,
    input wire logic estop_alarm_out,
    input wire logic [7:0] alarm_code_out,
    input wire logic [seq_pkg::POS_W-1:0] latch_pos_a_out,
    input wire logic [2:0] latch_done_out,
    input wire logic fwd_prohibit_out,
    input wire logic rev_prohibit_out,
    input wire logic [1:0] stop_method_out
);
    import seq_pkg::*;
    logic [2:0] up_q;
    logic [2:0] up_d;
    logic [SPEED_W-1:0] cmd_exp;
    default clocking @(posedge sys_clk_in); endclocking
    default disable iff (rst_in);
    // Counts cycles since reset so that history checks skip the first edges.
    always_comb begin
        up_d = rst_in ? 3'h0 : up_q + {2'h0, up_q != 3'h7};
        cmd_exp = (speed_cmd_mag_in > speed_limit_out) ? speed_limit_out : speed_cmd_mag_in;
    end
    always_ff @(posedge sys_clk_in) begin
        up_q <= up_d;
    end
    sequence settled_s;
        up_q == 3'h7;
    endsequence
    sequence torque_s;
        up_q == 3'h7 && $past(torque_mode_in);
    endsequence
    sequence estop_off_s;
        estop_input_enable_n_in [*3];
    endsequence
    sequence ot_off_s;
        !overtravel_input_enable_in [*2];
    endsequence
    alarm_code_a: assert property (alarm_code_out == (estop_alarm_out ? ESTOP_ALARM_CODE : 8'h00))
        else $error("alarm code wrong");
    estop_off_a: assert property (estop_off_s |-> !estop_alarm_out)
        else $error("alarm while disabled");
    latch_pos_a: assert property (settled_s ##0 latch_done_out[0] |-> latch_pos_a_out == $past(fb_pos_in))
        else $error("latch position wrong");
    done_pulse_a: assert property (latch_done_out != 3'h0 |=> (latch_done_out & $past(latch_done_out)) == 3'h0)
        else $error("done pulse too long");
    speed_cap_a: assert property (torque_s |-> speed_cmd_limited_out == $past(cmd_exp))
        else $error("command not capped");
    ot_off_a: assert property (ot_off_s |=> !fwd_prohibit_out && !rev_prohibit_out)
        else $error("prohibit while disabled");
    one_stop_a: assert property (!(fwd_prohibit_out && rev_prohibit_out))
        else $error("both prohibits set");
    method_pass_a: assert property (settled_s |-> stop_method_out == $past(overtravel_stop_method_in))
        else $error("stop method wrong");
endmodule
bind servo_seq_ctrl servo_seq_props servo_seq_props_i (.*);

// ---- dv/tb_top.sv ----
// Self-checking bench for the speed limit and sequence input block.
// Assumes the field model drives the pins and the checker is bound in.
`timescale 1ns/1ps
module tb_top;
    import seq_pkg::*;
    logic sys_clk_in = 1'b0;
    logic rst_in = 1'b1;
    logic torque_mode_in = 1'b1;
    logic speed_limit_source_sel_in = 1'b0;
    logic estop_input_enable_n_in = 1'b0;
    logic overtravel_input_enable_in = 1'b1;
    logic origin_prox_polarity_in = 1'b0;
    logic [1:0] overtravel_stop_method_in = 2'h2;
    logic [1:0] overtravel_pin_assign_in = 2'h0;
    logic [3:0] torque_limit_sel_in = 4'h3;
    logic [15:0] net_speed_limit_in = '0;
    logic [15:0] speed_cmd_mag_in = '0;
    logic [15:0] lim_req = '0;
    logic [11:0] want = '0;
    logic [11:0] pins;
    logic [15:0] internal_speed_limit_in, speed_limit_out, speed_cmd_limited_out;
    logic [31:0] fb_pos_in, latch_pos_a_out, latch_pos_b_out, latch_pos_c_out;
    logic [7:0] alarm_code_out;
    logic [2:0] latch_done_out, gp_inputs_out;
    logic [1:0] stop_method_out;
    logic speed_limited_out, estop_alarm_out, use_fwd_tlim_out, use_rev_tlim_out;
    logic fwd_prohibit_out, rev_prohibit_out, origin_prox_out;
    int fail_count = 0;
    int total_checks = 0;
    field_model field_model_i (.sys_clk_in, .rst_in, .want_in(want), .lim_req_in(lim_req), .pins_out(pins),
        .internal_lim_out(internal_speed_limit_in), .fb_pos_out(fb_pos_in));
    servo_seq_ctrl servo_seq_ctrl_i (.*, .estop_in(pins[0]), .latch_in_a_in(pins[1]), .latch_in_b_in(pins[2]),
        .latch_in_c_in(pins[3]), .fwd_torque_lim_in(pins[4]), .rev_torque_lim_in(pins[5]),
        .fwd_overtravel_in(pins[6]), .rev_overtravel_in(pins[7]), .origin_prox_in(pins[8]),
        .gp_input_zero_in(pins[9]), .gp_input_one_in(pins[10]), .gp_input_two_in(pins[11]));
    always #2.5 sys_clk_in = ~sys_clk_in;
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("FAIL %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic finish_test();
        $display("checks %0d mismatches %0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    // Waits out the debounce, checking every capture against the feedback counter.
    task automatic settle(input logic [2:0] exp_done);
        logic [2:0] seen;
        seen = 3'h0;
        repeat (20050) begin
            @(negedge sys_clk_in);
            if (latch_done_out[0]) check("latch a", latch_pos_a_out, fb_pos_in);
            if (latch_done_out[1]) check("latch b", latch_pos_b_out, fb_pos_in);
            if (latch_done_out[2]) check("latch c", latch_pos_c_out, fb_pos_in);
            seen = seen | latch_done_out;
        end
        check("latch pulses", 32'(seen), 32'(exp_done));
    endtask
    // Compares {alarm code, alarm, torque limit use, prohibits, method, proximity, general inputs}.
    task automatic outs(input logic [18:0] exp);
        logic [18:0] seen;
        seen = {alarm_code_out, estop_alarm_out, use_fwd_tlim_out, use_rev_tlim_out, fwd_prohibit_out,
            rev_prohibit_out, stop_method_out, origin_prox_out, gp_inputs_out};
        check("outputs", 32'(seen), 32'(exp));
    endtask
    task automatic speed_test();
        logic [15:0] il [5] = '{16'h03e8, 16'h03e8, 16'h03e8, 16'h0384, 16'h03e8};
        logic [15:0] nl [5] = '{16'h01f4, 16'h01f4, 16'h07d0, 16'h0384, 16'h01f4};
        logic [15:0] cl [5] = '{16'h04b0, 16'h0320, 16'h0320, 16'h0383, 16'h04b0};
        logic [15:0] lim;
        logic capped;
        for (int i = 0; i < 5; i++) begin
            @(negedge sys_clk_in);
            torque_mode_in = (i != 4);
            lim_req = il[i];
            net_speed_limit_in = nl[i];
            speed_limit_source_sel_in = (i != 0);
            speed_cmd_mag_in = cl[i];
            repeat (4) @(negedge sys_clk_in);
            lim = (i != 0 && nl[i] < il[i]) ? nl[i] : il[i];
            check("speed limit", 32'(speed_limit_out), 32'(lim));
            capped = (i != 4) && (cl[i] > lim);
            check("capped command", 32'(speed_cmd_limited_out), 32'(capped ? lim : cl[i]));
            check("limited flag", 32'(speed_limited_out), 32'(capped));
        end
        torque_mode_in = 1'b1;
    endtask
    task automatic inputs_on();
        want = 12'hf5e;
        settle(3'h7);
        outs(19'h2beaf);
    endtask
    task automatic inputs_swap();
        want = 12'h3a1;
        torque_limit_sel_in = 4'h5;
        overtravel_stop_method_in = 2'h1;
        origin_prox_polarity_in = 1'b1;
        settle(3'h0);
        outs(19'h00151);
    endtask
    task automatic settings_only();
        torque_limit_sel_in = 4'h4;
        overtravel_input_enable_in = 1'b0;
        repeat (4) @(negedge sys_clk_in);
        outs(19'h00011);
        overtravel_pin_assign_in = 2'h1;
        overtravel_input_enable_in = 1'b1;
        repeat (4) @(negedge sys_clk_in);
        outs(19'h00091);
    endtask
    // A short latch pulse must be ignored; the stop input is masked, then unmasked.
    task automatic estop_mask();
        estop_input_enable_n_in = 1'b1;
        want = 12'h1a2;
        repeat (100) @(negedge sys_clk_in);
        want = 12'h1a0;
        settle(3'h0);
        outs(19'h00090);
        estop_input_enable_n_in = 1'b0;
        repeat (4) @(negedge sys_clk_in);
        outs(19'h2bc90);
    endtask
    initial begin
        #400000;
        fail_count++;
        finish_test();
    end
    initial begin
        repeat (3) @(negedge sys_clk_in);
        rst_in = 1'b0;
        speed_test();
        inputs_on();
        inputs_swap();
        settings_only();
        estop_mask();
        finish_test();
    end
endmodule
